// *** dv/rdc_cmd_top_bench.sv ***
// self-checking bench for the direct command and transmit length block
`timescale 1ns/1ps
`default_nettype none
module rdc_cmd_top_bench;
	import rdc_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst, en, timer_done, tx_eof, rx_dig, rssi_valid, noise_on;
	logic rx_wait_set, rx_wait_done;
	logic [1:0] proto_sel;
	logic [2:0] rssi_level;
	wire logic cmd_stb, wr_stb, rd_stb, fifo_data;
	wire logic [7:0] cmd_word, wr_data, rd_data;
	wire logic [4:0] wr_addr, rd_addr;
	logic tx_start, tx_crc, tx_busy, tx_partial, next_slot, soft_init, fifo_clr, coll_clr;
	logic rx_block, rx_active, rf_int, rf_ext, gain_busy;
	logic [11:0] tx_bytes;
	logic [2:0] tx_last_bits, rssi_code;
	logic [1:0] slot_proto, gain_step;
	int n_errors = 0;
	int samples_checked = 0;
	// event index: 0 start 1 slot 2 init 3 fifo 4 coll 5 rfint 6 rfext 7 busy 8 blk 9 act 10 gain
	wire logic [10:0] obs;
	assign obs = {gain_busy, rx_active, rx_block, tx_busy, rf_ext, rf_int, coll_clr, fifo_clr,
		soft_init, next_slot, tx_start};
	always #4 mclk = ~mclk;
	// receive noise at the link rate, off-phase with the system clock
	initial begin
		rx_dig = 1'b0;
		#5;
		forever begin
			#32;
			if (noise_on) rx_dig = ~rx_dig;
		end
	end
	rdc_cmd_top #(.GAIN_WIN_CYCLES(64)) u_rdc_cmd_top (.MCLK_I(mclk), .SYS_RST_I(sys_rst),
		.EN_I(en), .CMD_STB_I(cmd_stb), .CMD_WORD_I(cmd_word), .WR_STB_I(wr_stb),
		.WR_ADDR_I(wr_addr), .WR_DATA_I(wr_data), .RD_STB_I(rd_stb), .RD_ADDR_I(rd_addr),
		.RD_DATA_O(rd_data), .FIFO_HAS_DATA_I(fifo_data), .TX_TIMER_DONE_I(timer_done),
		.TX_EOF_I(tx_eof), .PROTO_SEL_I(proto_sel), .RX_WAIT_SET_I(rx_wait_set),
		.RX_WAIT_DONE_I(rx_wait_done), .RX_DIG_I(rx_dig), .RSSI_VALID_I(rssi_valid),
		.RSSI_LEVEL_I(rssi_level), .TX_START_O(tx_start), .TX_CRC_O(tx_crc),
		.TX_BUSY_O(tx_busy), .TX_BYTES_O(tx_bytes), .TX_PARTIAL_O(tx_partial),
		.TX_LAST_BITS_O(tx_last_bits), .NEXT_SLOT_O(next_slot), .SLOT_PROTO_O(slot_proto),
		.SOFT_INIT_O(soft_init), .FIFO_CLR_O(fifo_clr), .COLL_CLR_O(coll_clr),
		.RX_BLOCK_O(rx_block), .RX_ACTIVE_O(rx_active), .RF_TEST_INT_O(rf_int),
		.RF_TEST_EXT_O(rf_ext), .RSSI_CODE_O(rssi_code), .GAIN_STEP_O(gain_step),
		.GAIN_BUSY_O(gain_busy));
	rdc_host_model u_rdc_host_model (.clk_i(mclk), .cmd_stb_o(cmd_stb), .cmd_word_o(cmd_word),
		.wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
		.rd_addr_o(rd_addr), .rd_data_i(rd_data), .fifo_has_data_o(fifo_data));
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [11:0] got, input logic [11:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask
	task automatic wait_obs(input int idx, input logic val, input int bound, input string msg);
		samples_checked++;
		for (int i = 0; i < bound; i++) begin
			if (obs[idx] === val) return;
			@(posedge mclk);
			#1;
		end
		n_errors++;
		$display("CHECK FAILED at %0t: %s not seen", $time, msg);
		test_done();
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic strobe(input int which);
		@(posedge mclk);
		if (which == 0) tx_eof <= 1'b1;
		else if (which == 1) timer_done <= 1'b1;
		else if (which == 2) rssi_valid <= 1'b1;
		else rx_wait_done <= 1'b1;
		@(posedge mclk);
		tx_eof <= 1'b0;
		timer_done <= 1'b0;
		rssi_valid <= 1'b0;
		rx_wait_done <= 1'b0;
		#1;
	endtask
	task automatic t_regs;
		logic [7:0] d;
		u_rdc_host_model.rd(RDC_OFS_TXLEN_HI, d);
		check(d, 8'h00, "hi reset");
		u_rdc_host_model.rd(RDC_OFS_TXLEN_LO, d);
		check(d, 8'h00, "lo reset");
		u_rdc_host_model.rd(5'h05, d);
		check(d, 8'h00, "unmapped");
		u_rdc_host_model.wr(RDC_OFS_TXLEN_HI, 8'hA5);
		u_rdc_host_model.wr(RDC_OFS_TXLEN_LO, 8'h35);
		check(tx_bytes, 12'hA53, "count");
		check(tx_partial, 1'b1, "flag");
		check(tx_last_bits, 3'h2, "bits");
		u_rdc_host_model.rd(RDC_OFS_TXLEN_HI, d);
		check(d, 8'hA5, "hi read");
		u_rdc_host_model.wr(RDC_OFS_TXLEN_LO, 8'h3A);
		check(tx_partial, 1'b0, "flag off");
		check(tx_last_bits, 3'h0, "bits ignored");
		$display("test regs done");
	endtask
	task automatic t_refuse;
		u_rdc_host_model.raw(8'hD1);
		u_rdc_host_model.raw(8'hB1);
		u_rdc_host_model.cmd(5'h15);
		u_rdc_host_model.cmd(RDC_CMD_IDLE);
		idle(3);
		check(tx_crc, 1'b0, "crc refused");
		check(tx_bytes, 12'hA53, "count kept");
		u_rdc_host_model.cmd(RDC_CMD_SW_INIT);
		wait_obs(2, 1'b1, 3, "init");
		idle(2);
		check(tx_bytes, 12'h000, "init clears");
		$display("test refuse done");
	endtask
	task automatic t_tx(input logic [4:0] c);
		u_rdc_host_model.send(c, 8'h01, 8'h2B);
		check(tx_bytes, 12'h012, "tx count");
		check(tx_last_bits, 3'h5, "tx bits");
		check(tx_crc, c[0], "crc mode");
		check(tx_busy, 1'b0, "no data yet");
		u_rdc_host_model.load(1'b1);
		if (c[1]) begin
			idle(10);
			check(tx_busy, 1'b0, "early start");
			strobe(1);
		end
		wait_obs(0, 1'b1, 4, "start");
		check(tx_busy, 1'b1, "busy");
		strobe(0);
		u_rdc_host_model.load(1'b0);
		wait_obs(7, 1'b0, 4, "frame end");
		check({tx_bytes[11:4], tx_bytes[3:0]}, 12'h000, "eof clears");
		check(tx_partial, 1'b0, "eof flag");
		$display("test tx %h done", c);
	endtask
	task automatic t_rx;
		u_rdc_host_model.cmd(RDC_CMD_RX_BLOCK);
		wait_obs(8, 1'b1, 3, "block");
		u_rdc_host_model.cmd(RDC_CMD_RX_ENABLE);
		wait_obs(8, 1'b0, 3, "unblock");
		check(rx_active, 1'b1, "active");
		u_rdc_host_model.cmd(RDC_CMD_RX_BLOCK);
		wait_obs(8, 1'b1, 3, "block again");
		t_tx(RDC_CMD_DTX);
		check(rx_block, 1'b0, "eof unblocks");
		rx_wait_set <= 1'b1;
		u_rdc_host_model.cmd(RDC_CMD_RX_BLOCK);
		strobe(0);
		idle(2);
		check(rx_block, 1'b1, "wait holds block");
		strobe(3);
		check(rx_block, 1'b0, "wait end unblocks");
		rx_wait_set <= 1'b0;
		$display("test rx done");
	endtask
	task automatic t_misc;
		logic [7:0] d;
		proto_sel <= 2'h2;
		u_rdc_host_model.cmd(RDC_CMD_NEXT_SLOT);
		wait_obs(1, 1'b1, 3, "slot");
		check(slot_proto, 2'h2, "slot form");
		u_rdc_host_model.cmd(RDC_CMD_RESET);
		wait_obs(3, 1'b1, 3, "fifo clear");
		wait_obs(4, 1'b1, 1, "coll clear");
		u_rdc_host_model.rf_test(RDC_CMD_RF_INT);
		wait_obs(5, 1'b1, 3, "rf int");
		u_rdc_host_model.rf_test(RDC_CMD_RF_EXT);
		wait_obs(6, 1'b1, 3, "rf ext");
		rssi_level <= 3'h5;
		strobe(2);
		check(rssi_code, 3'h5, "rssi");
		u_rdc_host_model.rd(RDC_OFS_RSSI, d);
		check(d, 8'h05, "rssi read");
		$display("test misc done");
	endtask
	task automatic t_gain;
		logic [7:0] d;
		u_rdc_host_model.cmd(RDC_CMD_GAIN_ADJ);
		wait_obs(10, 1'b1, 4, "gain go");
		wait_obs(10, 1'b0, 300, "quiet end");
		check(gain_step, 2'h0, "quiet step");
		noise_on = 1'b1;
		u_rdc_host_model.cmd(RDC_CMD_GAIN_ADJ);
		wait_obs(10, 1'b1, 4, "noisy go");
		wait_obs(10, 1'b0, 700, "noisy end");
		noise_on = 1'b0;
		check(gain_step, 2'h3, "step cap");
		u_rdc_host_model.rd(RDC_OFS_GAIN, d);
		check(d, 8'h03, "gain read");
		u_rdc_host_model.wr(RDC_OFS_TXLEN_HI, 8'hFF);
		en <= 1'b0;
		idle(8);
		check(gain_step, 2'h0, "gain max");
		check(tx_bytes, 12'h000, "en clears");
		en <= 1'b1;
		idle(8);
		$display("test gain done");
	endtask
	initial begin
		sys_rst = 1'b1;
		en = 1'b1;
		timer_done = 1'b0;
		tx_eof = 1'b0;
		rx_wait_set = 1'b0;
		rx_wait_done = 1'b0;
		rssi_valid = 1'b0;
		noise_on = 1'b0;
		proto_sel = 2'h0;
		rssi_level = 3'h0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		idle(8);
		t_regs();
		t_refuse();
		t_tx(RDC_CMD_TX);
		t_tx(RDC_CMD_TX_CRC);
		t_tx(RDC_CMD_DTX_CRC);
		t_rx();
		t_misc();
		t_gain();
		test_done();
	end
endmodule
`default_nettype wire

// *** dv/rdc_host_model.sv ***
// host side model: command words, register accesses and payload presence
`timescale 1ns/1ps
`default_nettype none
module rdc_host_model (
	// clock
	input wire logic clk_i,
	// command and register port
	output logic cmd_stb_o,
	output logic [7:0] cmd_word_o,
	output logic wr_stb_o,
	output logic [4:0] wr_addr_o,
	output logic [7:0] wr_data_o,
	output logic rd_stb_o,
	output logic [4:0] rd_addr_o,
	input wire logic [7:0] rd_data_i,
	// payload present in the fifo
	output logic fifo_has_data_o
);
	import rdc_pkg::*;
	initial begin
		cmd_stb_o = 1'b0;
		cmd_word_o = 8'h00;
		wr_stb_o = 1'b0;
		wr_addr_o = 5'h00;
		wr_data_o = 8'h00;
		rd_stb_o = 1'b0;
		rd_addr_o = 5'h00;
		fifo_has_data_o = 1'b0;
	end
	// released fields show the inverse so stale values never look valid
	task automatic raw(input logic [7:0] w);
		@(posedge clk_i);
		cmd_stb_o <= 1'b1;
		cmd_word_o <= w;
		@(posedge clk_i);
		cmd_stb_o <= 1'b0;
		cmd_word_o <= ~w;
		#1;
	endtask
	task automatic cmd(input logic [4:0] c);
		raw({3'b100, c});
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_stb_o <= 1'b1;
		wr_addr_o <= a;
		wr_data_o <= d;
		@(posedge clk_i);
		wr_stb_o <= 1'b0;
		wr_addr_o <= ~a;
		wr_data_o <= ~d;
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_stb_o <= 1'b1;
		rd_addr_o <= a;
		@(posedge clk_i);
		rd_stb_o <= 1'b0;
		rd_addr_o <= ~a;
		#1;
		d = rd_data_i;
	endtask
	// transmit command first, then both length bytes
	task automatic send(input logic [4:0] c, input logic [7:0] hi, input logic [7:0] lo);
		cmd(c);
		wr(RDC_OFS_TXLEN_HI, hi);
		wr(RDC_OFS_TXLEN_LO, lo);
	endtask
	task automatic load(input logic v);
		@(posedge clk_i);
		fifo_has_data_o <= v;
		#1;
	endtask
	// rf tests only with the receiver enabled beforehand
	task automatic rf_test(input logic [4:0] c);
		cmd(RDC_CMD_RX_ENABLE);
		cmd(c);
	endtask
endmodule
`default_nettype wire

// *** verilog/rdc_cmd_top.sv ***
// direct command decoder and transmit length registers of the reader front end
//
// Behaviour
// - length byte one holds count bits 11..4
// - length byte two upper nibble: count 3..0
// - length registers clear at reset, disable, frame end
// - bit zero flags a partial last byte
// - bits 3..1 count partial bits, flag-gated
// - decode idle, software init, reset commands
// - decode immediate and delayed sends, CRC or not
// - decode next slot, receiver block, enable
// - decode internal, external RF tests, gain adjust
// - reset command strobes FIFO clear and collision clear
// - immediate send starts on first FIFO byte
// - delayed send waits for transmit timer
// - next slot signal follows selected protocol
// - gain adjust counts edges per window
// - five dB steps, fifteen dB at most
// - gain returns to maximum on reset, disable
// - external test stores level code
// - level codes one to seven by input
// - RF tests need receiver enabled first; the decoder starts them regardless
// - command words: bit seven set, six five clear
// - block holds receiver until enable, send end, or wait end when wait set
// - enable command releases blocked receiver
`timescale 1ns/1ps
`default_nettype none
module rdc_cmd_top #(
	parameter int GAIN_WIN_CYCLES = rdc_pkg::RDC_GAIN_WIN_CYC
) (
	// clock and reset
	input wire logic MCLK_I,
	input wire logic SYS_RST_I,
	// chip enable pin, asynchronous
	input wire logic EN_I,
	// command words from the host port logic
	input wire logic CMD_STB_I,
	input wire logic [7:0] CMD_WORD_I,
	// register access from the host port logic
	input wire logic WR_STB_I,
	input wire logic [4:0] WR_ADDR_I,
	input wire logic [7:0] WR_DATA_I,
	input wire logic RD_STB_I,
	input wire logic [4:0] RD_ADDR_I,
	output logic [7:0] RD_DATA_O,
	// transmit side status
	input wire logic FIFO_HAS_DATA_I,
	input wire logic TX_TIMER_DONE_I,
	input wire logic TX_EOF_I,
	input wire logic [1:0] PROTO_SEL_I,
	// receiver side status
	input wire logic RX_WAIT_SET_I,
	input wire logic RX_WAIT_DONE_I,
	input wire logic RX_DIG_I,
	input wire logic RSSI_VALID_I,
	input wire logic [2:0] RSSI_LEVEL_I,
	// transmit control
	output logic TX_START_O,
	output logic TX_CRC_O,
	output logic TX_BUSY_O,
	output logic [11:0] TX_BYTES_O,
	output logic TX_PARTIAL_O,
	output logic [2:0] TX_LAST_BITS_O,
	output logic NEXT_SLOT_O,
	output logic [1:0] SLOT_PROTO_O,
	// housekeeping strobes
	output logic SOFT_INIT_O,
	output logic FIFO_CLR_O,
	output logic COLL_CLR_O,
	// receiver control
	output logic RX_BLOCK_O,
	output logic RX_ACTIVE_O,
	output logic RF_TEST_INT_O,
	output logic RF_TEST_EXT_O,
	output logic [2:0] RSSI_CODE_O,
	output logic [1:0] GAIN_STEP_O,
	output logic GAIN_BUSY_O
);
	import rdc_pkg::*;

	// chip enable synchroniser
	logic en1_q, en2_q, en3_q, en_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			en1_q <= 1'b0;
			en2_q <= 1'b0;
			en3_q <= 1'b0;
			en_q <= 1'b0;
		end else begin
			en1_q <= EN_I;
			en2_q <= en1_q;
			en3_q <= en2_q;
			if (en2_q == en3_q) begin
				en_q <= en3_q;
			end
		end
	end

	// command decode
	logic cmd_ok_w;
	logic [4:0] code_w;
	logic init_q;
	logic clr_w;
	assign code_w = CMD_WORD_I[4:0]; // only listed codes match a decode below
	assign cmd_ok_w = CMD_STB_I && CMD_WORD_I[RDC_CMD_MARK_POS]
		&& !CMD_WORD_I[RDC_CMD_RW_POS] && !CMD_WORD_I[RDC_CMD_CONT_POS];
	// software init acts one cycle later exactly as a disable would
	assign clr_w = !en_q || init_q;

	logic is_tx_w, is_dtx_w, is_crc_w;
	assign is_tx_w = cmd_ok_w && (code_w == RDC_CMD_TX || code_w == RDC_CMD_TX_CRC);
	assign is_dtx_w = cmd_ok_w && (code_w == RDC_CMD_DTX || code_w == RDC_CMD_DTX_CRC);
	assign is_crc_w = code_w == RDC_CMD_TX_CRC || code_w == RDC_CMD_DTX_CRC;

	// housekeeping strobes
	logic fifo_clr_q, coll_clr_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			init_q <= 1'b0;
			fifo_clr_q <= 1'b0;
			coll_clr_q <= 1'b0;
		end else begin
			init_q <= cmd_ok_w && code_w == RDC_CMD_SW_INIT;
			fifo_clr_q <= cmd_ok_w && code_w == RDC_CMD_RESET;
			coll_clr_q <= cmd_ok_w && code_w == RDC_CMD_RESET;
		end
	end

	// transmit length registers
	logic [7:0] len_hi_q, len_lo_q;
	logic [2:0] last_bits_q;
	logic wr_hi_w, wr_lo_w;
	assign wr_hi_w = WR_STB_I && WR_ADDR_I == RDC_OFS_TXLEN_HI;
	assign wr_lo_w = WR_STB_I && WR_ADDR_I == RDC_OFS_TXLEN_LO;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			len_hi_q <= RDC_TXLEN_RST;
		end else if (wr_hi_w) begin
			len_hi_q <= WR_DATA_I;
		end else if (TX_EOF_I) begin
			len_hi_q <= RDC_TXLEN_RST;
		end
	end
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			len_lo_q <= RDC_TXLEN_RST;
			last_bits_q <= 3'h0;
		end else if (wr_lo_w) begin
			len_lo_q <= WR_DATA_I;
			// the bit count is only meaningful behind the partial flag
			last_bits_q <= WR_DATA_I[RDC_PART_FLAG_POS] ?
				WR_DATA_I[RDC_PART_BITS_LSB +: 3] : 3'h0;
		end else if (TX_EOF_I) begin
			len_lo_q <= RDC_TXLEN_RST;
			last_bits_q <= 3'h0;
		end
	end

	// transmit sequencer
	rdc_tx_e tx_st_q;
	logic tx_start_q, tx_crc_q, tx_busy_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			tx_st_q <= RDC_TX_IDLE;
			tx_start_q <= 1'b0;
			tx_crc_q <= 1'b0;
			tx_busy_q <= 1'b0;
		end else begin
			tx_start_q <= 1'b0;
			if (is_tx_w && tx_st_q != RDC_TX_SENDING) begin
				tx_st_q <= RDC_TX_WAIT_DATA;
				tx_crc_q <= is_crc_w;
			end else if (is_dtx_w && tx_st_q != RDC_TX_SENDING) begin
				tx_st_q <= RDC_TX_WAIT_TIMER;
				tx_crc_q <= is_crc_w;
			end else begin
				case (tx_st_q)
					RDC_TX_IDLE: begin
						tx_st_q <= RDC_TX_IDLE;
					end
					RDC_TX_WAIT_DATA: begin
						if (FIFO_HAS_DATA_I) begin
							tx_st_q <= RDC_TX_SENDING;
							tx_start_q <= 1'b1;
							tx_busy_q <= 1'b1;
						end
					end
					RDC_TX_WAIT_TIMER: begin
						if (TX_TIMER_DONE_I) begin
							tx_st_q <= RDC_TX_SENDING;
							tx_start_q <= 1'b1;
							tx_busy_q <= 1'b1;
						end
					end
					RDC_TX_SENDING: begin
						if (TX_EOF_I) begin
							tx_st_q <= RDC_TX_IDLE;
							tx_busy_q <= 1'b0;
						end
					end
					default: begin
						tx_st_q <= RDC_TX_IDLE;
					end
				endcase
			end
		end
	end

	// next slot
	logic next_slot_q;
	logic [1:0] slot_proto_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			next_slot_q <= 1'b0;
			slot_proto_q <= 2'h0;
		end else begin
			next_slot_q <= cmd_ok_w && code_w == RDC_CMD_NEXT_SLOT;
			if (cmd_ok_w && code_w == RDC_CMD_NEXT_SLOT) begin
				slot_proto_q <= PROTO_SEL_I;
			end
		end
	end

	// receiver block and enable
	logic rx_block_q, rx_wait_q, rx_on_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			rx_block_q <= 1'b0;
			rx_wait_q <= 1'b0;
		end else if (cmd_ok_w && code_w == RDC_CMD_RX_ENABLE) begin
			rx_block_q <= 1'b0;
			rx_wait_q <= 1'b0;
		end else if (cmd_ok_w && code_w == RDC_CMD_RX_BLOCK) begin
			rx_block_q <= 1'b1;
			rx_wait_q <= 1'b0;
		end else if (rx_block_q && TX_EOF_I) begin
			if (RX_WAIT_SET_I) begin
				rx_wait_q <= 1'b1;
			end else begin
				rx_block_q <= 1'b0;
			end
		end else if (rx_wait_q && RX_WAIT_DONE_I) begin
			rx_block_q <= 1'b0;
			rx_wait_q <= 1'b0;
		end
	end
	// receive section comes alive after an exchange or the enable command
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			rx_on_q <= 1'b0;
		end else if ((cmd_ok_w && code_w == RDC_CMD_RX_ENABLE) || TX_EOF_I) begin
			rx_on_q <= 1'b1;
		end
	end

	// RF level tests
	logic rf_int_q, rf_ext_q, rssi_wait_q;
	logic [2:0] rssi_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			rf_int_q <= 1'b0;
			rf_ext_q <= 1'b0;
			rssi_wait_q <= 1'b0;
			rssi_q <= RDC_RSSI_RST[2:0];
		end else begin
			rf_int_q <= cmd_ok_w && code_w == RDC_CMD_RF_INT;
			rf_ext_q <= cmd_ok_w && code_w == RDC_CMD_RF_EXT;
			if (rf_int_q || rf_ext_q) begin
				rssi_wait_q <= 1'b1;
			end else if (rssi_wait_q && RSSI_VALID_I) begin
				// quantiser code 1..7 is stored as measured
				rssi_q <= RSSI_LEVEL_I;
				rssi_wait_q <= 1'b0;
			end
		end
	end

	// gain adjust engine
	logic gain_go_q;
	logic [1:0] gain_step_w;
	logic gain_busy_w;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I || clr_w) begin
			gain_go_q <= 1'b0;
		end else begin
			gain_go_q <= cmd_ok_w && code_w == RDC_CMD_GAIN_ADJ;
		end
	end
	rdc_gain_adj #(
		.WIN_CYCLES(GAIN_WIN_CYCLES)
	) u_gain (
		.clk_i(MCLK_I),
		.rst_i(SYS_RST_I),
		.clr_i(clr_w),
		.start_i(gain_go_q),
		.rx_dig_i(RX_DIG_I),
		.step_o(gain_step_w),
		.busy_o(gain_busy_w)
	);

	// register read port
	logic [7:0] rd_q;
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			rd_q <= 8'h00;
		end else if (RD_STB_I) begin
			case (RD_ADDR_I)
				RDC_OFS_TXLEN_HI: rd_q <= len_hi_q;
				RDC_OFS_TXLEN_LO: rd_q <= len_lo_q;
				RDC_OFS_RSSI: rd_q <= {5'h00, rssi_q};
				RDC_OFS_GAIN: rd_q <= {5'h00, gain_busy_w, gain_step_w};
				default: rd_q <= 8'h00;
			endcase
		end
	end

	assign RD_DATA_O = rd_q;
	assign TX_START_O = tx_start_q;
	assign TX_CRC_O = tx_crc_q;
	assign TX_BUSY_O = tx_busy_q;
	assign TX_BYTES_O = {len_hi_q, len_lo_q[7:RDC_CNT_LOW_LSB]};
	assign TX_PARTIAL_O = len_lo_q[RDC_PART_FLAG_POS];
	assign TX_LAST_BITS_O = last_bits_q;
	assign NEXT_SLOT_O = next_slot_q;
	assign SLOT_PROTO_O = slot_proto_q;
	assign SOFT_INIT_O = init_q;
	assign FIFO_CLR_O = fifo_clr_q;
	assign COLL_CLR_O = coll_clr_q;
	assign RX_BLOCK_O = rx_block_q;
	assign RX_ACTIVE_O = rx_on_q;
	assign RF_TEST_INT_O = rf_int_q;
	assign RF_TEST_EXT_O = rf_ext_q;
	assign RSSI_CODE_O = rssi_q;
	assign GAIN_STEP_O = gain_step_w;
	assign GAIN_BUSY_O = gain_busy_w;

	// checks
	len_eof_clr_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		(TX_EOF_I && !wr_hi_w && !wr_lo_w) |=> (len_hi_q == 8'h00 && len_lo_q == 8'h00))
		else $error("length not cleared at frame end");
	len_write_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		(wr_hi_w && !clr_w) |=> TX_BYTES_O[11:4] == $past(WR_DATA_I))
		else $error("upper count not written");
	part_gate_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		!TX_PARTIAL_O |-> TX_LAST_BITS_O == 3'h0) else $error("bit count without flag");
	rst_cmd_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		(cmd_ok_w && code_w == RDC_CMD_RESET) |=> (FIFO_CLR_O && COLL_CLR_O)
		##1 (!FIFO_CLR_O || $past(cmd_ok_w && code_w == RDC_CMD_RESET)))
		else $error("reset command strobes wrong");
	tx_imm_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I || clr_w)
		(tx_st_q == RDC_TX_WAIT_DATA && FIFO_HAS_DATA_I && !is_tx_w && !is_dtx_w)
		|=> TX_START_O && TX_BUSY_O) else $error("immediate send did not start");
	tx_timer_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		$rose(TX_START_O) && $past(tx_st_q) == RDC_TX_WAIT_TIMER |-> $past(TX_TIMER_DONE_I))
		else $error("delayed send started before timer");
	rx_block_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I || clr_w)
		(cmd_ok_w && code_w == RDC_CMD_RX_BLOCK) |=> RX_BLOCK_O)
		else $error("receiver not blocked");
	rx_enable_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I || clr_w)
		(cmd_ok_w && code_w == RDC_CMD_RX_ENABLE) |=> !RX_BLOCK_O && RX_ACTIVE_O)
		else $error("receiver not released");
	bad_word_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		(CMD_STB_I && !cmd_ok_w && !WR_STB_I && !TX_EOF_I && en_q && !init_q)
		|=> $stable(len_hi_q) && !TX_START_O && !FIFO_CLR_O)
		else $error("non-command word acted");
	init_clr_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
		(cmd_ok_w && code_w == RDC_CMD_SW_INIT) |=> ##1 (GAIN_STEP_O == 2'h0 && !RX_BLOCK_O))
		else $error("software init did not clear");
endmodule
`default_nettype wire

// *** verilog/rdc_gain_adj.sv ***
// receiver gain adjust engine: counts receive edges per window, steps threshold
`timescale 1ns/1ps
`default_nettype none
module rdc_gain_adj #(
	parameter int WIN_CYCLES = rdc_pkg::RDC_GAIN_WIN_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic clr_i,
	input wire logic start_i,
	// digitized receive signal, asynchronous
	input wire logic rx_dig_i,
	// result
	output logic [1:0] step_o,
	output logic busy_o
);
	import rdc_pkg::*;

	logic s1_q, s2_q, s3_q, stable_q;
	logic edge_w;
	logic [31:0] win_q;
	logic [1:0] edges_q;
	logic [1:0] step_q;
	logic busy_q;
	logic win_end_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			stable_q <= 1'b0;
		end else begin
			s1_q <= rx_dig_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				stable_q <= s3_q;
			end
		end
	end

	// a change counts once the last two stages agree on the new level
	assign edge_w = (s2_q == s3_q) && (s3_q != stable_q);
	assign win_end_w = busy_q && (win_q == 32'(WIN_CYCLES - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			win_q <= 32'h0;
			edges_q <= 2'h0;
		end else if (start_i || win_end_w || !busy_q) begin
			win_q <= 32'h0;
			edges_q <= 2'h0;
		end else begin
			win_q <= win_q + 32'h1;
			if (edge_w && edges_q != 2'h3) begin
				edges_q <= edges_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			step_q <= RDC_GAIN_RST;
			busy_q <= 1'b0;
		end else if (start_i && !busy_q) begin
			busy_q <= 1'b1;
		end else if (win_end_w) begin
			// more than two changes raise the threshold, else the search ends
			if (edges_q > RDC_EDGE_LIMIT && step_q != RDC_GAIN_MAX_STEPS) begin
				step_q <= step_q + 2'h1;
			end else begin
				busy_q <= 1'b0;
			end
		end
	end

	assign step_o = step_q;
	assign busy_o = busy_q;

	step_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
		step_q <= RDC_GAIN_MAX_STEPS) else $error("gain steps beyond 15 dB");
	step_win_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(step_q != $past(step_q) && !$past(clr_i) && !$past(rst_i)) |-> $past(win_end_w))
		else $error("gain stepped outside a window end");
endmodule
`default_nettype wire

// *** verilog/rdc_pkg.sv ***
// constants shared by the direct-command and transmit-length logic
package rdc_pkg;
	// register offsets
	localparam logic [4:0] RDC_OFS_TXLEN_HI = 5'h1D;
	localparam logic [4:0] RDC_OFS_TXLEN_LO = 5'h1E;
	localparam logic [4:0] RDC_OFS_RSSI = 5'h0F;
	localparam logic [4:0] RDC_OFS_GAIN = 5'h1F;
	localparam logic [7:0] RDC_TXLEN_RST = 8'h00;
	localparam logic [7:0] RDC_RSSI_RST = 8'h00;
	// field positions in the lower length register
	localparam int RDC_PART_FLAG_POS = 0;
	localparam int RDC_PART_BITS_LSB = 1;
	localparam int RDC_CNT_LOW_LSB = 4;
	// command word layout
	localparam int RDC_CMD_MARK_POS = 7;
	localparam int RDC_CMD_RW_POS = 6;
	localparam int RDC_CMD_CONT_POS = 5;
	// command codes
	localparam logic [4:0] RDC_CMD_IDLE = 5'h00;
	localparam logic [4:0] RDC_CMD_SW_INIT = 5'h03;
	localparam logic [4:0] RDC_CMD_RESET = 5'h0F;
	localparam logic [4:0] RDC_CMD_TX = 5'h10;
	localparam logic [4:0] RDC_CMD_TX_CRC = 5'h11;
	localparam logic [4:0] RDC_CMD_DTX = 5'h12;
	localparam logic [4:0] RDC_CMD_DTX_CRC = 5'h13;
	localparam logic [4:0] RDC_CMD_NEXT_SLOT = 5'h14;
	localparam logic [4:0] RDC_CMD_RX_BLOCK = 5'h16;
	localparam logic [4:0] RDC_CMD_RX_ENABLE = 5'h17;
	localparam logic [4:0] RDC_CMD_RF_INT = 5'h18;
	localparam logic [4:0] RDC_CMD_RF_EXT = 5'h19;
	localparam logic [4:0] RDC_CMD_GAIN_ADJ = 5'h1A;
	// gain adjust timing and limits
	localparam int RDC_CLK_PERIOD_PS = 8000;
	localparam int RDC_GAIN_WIN_US = 100;
	localparam int RDC_GAIN_WIN_CYC = (RDC_GAIN_WIN_US * 1000000) / RDC_CLK_PERIOD_PS;
	localparam int RDC_GAIN_DB_STEP = 5;
	localparam int RDC_GAIN_DB_MAX = 15;
	localparam logic [1:0] RDC_GAIN_MAX_STEPS = 2'(RDC_GAIN_DB_MAX / RDC_GAIN_DB_STEP);
	localparam logic [1:0] RDC_EDGE_LIMIT = 2'h2;
	localparam logic [1:0] RDC_GAIN_RST = 2'h0;
	// transmit sequencer states
	typedef enum logic [2:0] {
		RDC_TX_IDLE,
		RDC_TX_WAIT_DATA,
		RDC_TX_WAIT_TIMER,
		RDC_TX_SENDING
	} rdc_tx_e;
endpackage
